// *** hdl/eecnt_regs.vh ***
// Register offsets, field positions, reset values and encodings of the edge event counter
`ifndef EECNT_REGS_VH
`define EECNT_REGS_VH

// Register byte offsets
`define EECNT_ADDR_W        8
`define EECNT_OFS_CTRL      8'h00
`define EECNT_OFS_LOAD      8'h04
`define EECNT_OFS_COUNT     8'h08
`define EECNT_OFS_CMD       8'h0C
`define EECNT_OFS_STATUS    8'h10
`define EECNT_OFS_IRQ_EN    8'h14
`define EECNT_OFS_IRQ_CLR   8'h18
`define EECNT_OFS_STATE     8'h1C

// Control register fields
`define EECNT_CTRL_DOWN     0
`define EECNT_CTRL_EXTDIR   1
`define EECNT_CTRL_FALL     2
`define EECNT_CTRL_OMODE_LO 3
`define EECNT_CTRL_OMODE_HI 4
`define EECNT_CTRL_GMODE_LO 5
`define EECNT_CTRL_GMODE_HI 7
`define EECNT_CTRL_W        8
`define EECNT_CTRL_RST      8'h00

// Command register bits, self clearing
`define EECNT_CMD_LOAD      0
`define EECNT_CMD_START     1
`define EECNT_CMD_STOP      2

// Status, enable and clear bits
`define EECNT_EV_TC         0
`define EECNT_EV_GATE       1
`define EECNT_EV_W          2

// Output modes
`define EECNT_OM_PULSE      2'h0
`define EECNT_OM_TOGGLE     2'h1
`define EECNT_OM_TRAIN      2'h2

// Gating modes
`define EECNT_GM_SOFT       3'h0
`define EECNT_GM_HIGH       3'h1
`define EECNT_GM_LOW        3'h2
`define EECNT_GM_RISE       3'h3
`define EECNT_GM_FALL       3'h4

// Pin synchroniser depth
`define EECNT_SYNC_STAGES   3

`endif

// *** hdl/eecnt_sync.v ***
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module eecnt_sync #(
	parameter W = 3
) (
	input  wire         clk,
	input  wire         arst_n,
	input  wire [W-1:0] pin_in,
	output wire [W-1:0] level
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_lane
			reg s1_r;
			reg s2_r;
			reg s3_r;
			reg lvl_r;
			// The first stage feeds only the second; the filter looks at stages two and three
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					s1_r  <= 1'b0;
					s2_r  <= 1'b0;
					s3_r  <= 1'b0;
					lvl_r <= 1'b0;
				end else begin
					s1_r <= pin_in[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						lvl_r <= s3_r; // A change counts once two stages agree
					end
				end
			end
			assign level[i] = lvl_r;
		end
	endgenerate
endmodule // eecnt_sync

// *** hdl/eecnt_top.v ***
// Edge event counter: preloadable up/down counter of pin edges with gating and terminal count output
`timescale 1ns/1ps
`include "eecnt_regs.vh"
module eecnt_top #(
	parameter CW      = 32,
	parameter REDUCED = 0
) (
	input  wire                    clk,
	input  wire                    arst_n,
	input  wire                    src_pin,
	input  wire                    gate_pin,
	input  wire                    dir_pin,
	input  wire [`EECNT_ADDR_W-1:0] addr,
	input  wire [31:0]             wdata,
	input  wire                    wr,
	input  wire                    rd,
	output reg  [31:0]             rdata,
	output reg                     ctr_out_r,
	output reg                     irq_r
);
	// Synchronised pin levels
	wire [2:0] pin_lvl;
	wire       src_lvl  = pin_lvl[0];
	wire       gate_lvl = pin_lvl[1];
	wire       dir_lvl  = pin_lvl[2];

	eecnt_sync #(
		.W (3)
	) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.pin_in ({dir_pin, gate_pin, src_pin}),
		.level  (pin_lvl)
	);

	// Software-visible state
	reg [`EECNT_CTRL_W-1:0] ctrl_r;
	reg [CW-1:0]            load_r;
	reg [CW-1:0]            cnt_r;
	reg [`EECNT_EV_W-1:0]   stat_r;
	reg [`EECNT_EV_W-1:0]   ien_r;
	reg                     run_r;
	reg                     trig_r;
	reg                     pulse_r;
	reg                     tog_r;
	reg                     src_d_r;
	reg                     gate_d_r;

	// Effective configuration; the reduced variant pins edge, gating and direction but not the output mode
	wire [1:0] omode_raw = ctrl_r[`EECNT_CTRL_OMODE_HI:`EECNT_CTRL_OMODE_LO];
	wire [2:0] gmode_raw = ctrl_r[`EECNT_CTRL_GMODE_HI:`EECNT_CTRL_GMODE_LO];
	wire       reduced   = (REDUCED != 0);
	wire       use_fall  = reduced ? 1'b0 : ctrl_r[`EECNT_CTRL_FALL];
	wire [2:0] gmode     = reduced ? `EECNT_GM_HIGH : gmode_raw;
	wire [1:0] omode     = (!reduced && omode_raw == `EECNT_OM_TRAIN) ? `EECNT_OM_PULSE : omode_raw;
	wire       go_down   = reduced ? 1'b1 :
	                       (ctrl_r[`EECNT_CTRL_EXTDIR] ? dir_lvl : ctrl_r[`EECNT_CTRL_DOWN]);

	// Edge detection on the filtered source and gate
	wire src_rise  = src_lvl & ~src_d_r;
	wire src_fall  = ~src_lvl & src_d_r;
	wire cnt_edge  = use_fall ? src_fall : src_rise;
	wire gate_rise = gate_lvl & ~gate_d_r;
	wire gate_fall = ~gate_lvl & gate_d_r;

	// Bus decode
	wire wr_ctrl = wr && (addr == `EECNT_OFS_CTRL);
	wire wr_load = wr && (addr == `EECNT_OFS_LOAD);
	wire wr_cmd  = wr && (addr == `EECNT_OFS_CMD);
	wire wr_ien  = wr && (addr == `EECNT_OFS_IRQ_EN);
	wire wr_clr  = wr && (addr == `EECNT_OFS_IRQ_CLR);
	wire cmd_ld  = wr_cmd && wdata[`EECNT_CMD_LOAD];
	wire cmd_go  = wr_cmd && wdata[`EECNT_CMD_START];
	wire cmd_st  = wr_cmd && wdata[`EECNT_CMD_STOP];

	// Gate permission as seen at the counted edge: always set in software gating, the current gate level in level modes, or in edge gating modes the latched trigger
	reg gate_ok;
	reg trig_ev;
	always @* begin
		gate_ok = 1'b0;
		trig_ev = 1'b0;
		case (gmode)
			`EECNT_GM_SOFT: gate_ok = 1'b1;
			`EECNT_GM_HIGH: gate_ok = gate_lvl;
			`EECNT_GM_LOW:  gate_ok = ~gate_lvl;
			`EECNT_GM_RISE: begin
				trig_ev = run_r & ~trig_r & gate_rise;
				gate_ok = trig_r;
			end
			`EECNT_GM_FALL: begin
				trig_ev = run_r & ~trig_r & gate_fall;
				gate_ok = trig_r;
			end
			default: gate_ok = 1'b0;
		endcase
	end

	wire step = run_r && gate_ok && cnt_edge;

	// Next count value and terminal count detection
	localparam [CW-1:0] ALL_ONES = {CW{1'b1}};
	localparam [CW-1:0] ZERO     = {CW{1'b0}};
	localparam [CW-1:0] ONE      = {{(CW-1){1'b0}}, 1'b1};
	wire          train   = reduced && (omode_raw == `EECNT_OM_TRAIN);
	wire [CW-1:0] half    = {1'b0, load_r[CW-1:1]};
	reg  [CW-1:0] cnt_nxt;
	reg           tc_hit;
	always @* begin
		cnt_nxt = cnt_r;
		tc_hit  = 1'b0;
		if (step) begin
			if (train) begin
				// Reload at the end of each period so every period is exactly the loaded count
				if (cnt_r <= ONE) begin
					cnt_nxt = load_r;
					tc_hit  = 1'b1;
				end else begin
					cnt_nxt = cnt_r - ONE;
				end
			end else if (go_down) begin
				cnt_nxt = cnt_r - ONE;
				tc_hit  = (cnt_nxt == ZERO);
			end else begin
				cnt_nxt = cnt_r + ONE;
				tc_hit  = (cnt_nxt == ALL_ONES);
			end
		end
	end

	// Output line state; the pulse lasts until the next counted edge, one source period
	reg pulse_nxt;
	reg tog_nxt;
	reg out_nxt;
	always @* begin
		pulse_nxt = pulse_r;
		tog_nxt   = tog_r;
		if (cmd_ld) begin
			pulse_nxt = 1'b0;
		end else if (step) begin
			pulse_nxt = tc_hit && (omode == `EECNT_OM_PULSE);
			if (tc_hit && omode == `EECNT_OM_TOGGLE) begin
				tog_nxt = ~tog_r;
			end
		end
		case (omode)
			`EECNT_OM_TOGGLE: out_nxt = tog_nxt;
			`EECNT_OM_TRAIN:  out_nxt = (cnt_nxt > half);
			default:          out_nxt = reduced ? ~pulse_nxt : pulse_nxt;
		endcase
	end

	// Sticky events: hardware set wins over a same-cycle software clear
	wire [`EECNT_EV_W-1:0] ev_set   = {trig_ev, step & tc_hit};
	wire [`EECNT_EV_W-1:0] stat_nxt = (stat_r & ~(wr_clr ? wdata[`EECNT_EV_W-1:0] : {`EECNT_EV_W{1'b0}})) | ev_set;
	wire [`EECNT_EV_W-1:0] ien_nxt  = wr_ien ? wdata[`EECNT_EV_W-1:0] : ien_r;

	// Control and counting state
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r   <= `EECNT_CTRL_RST;
			load_r   <= ZERO;
			cnt_r    <= ZERO;
			run_r    <= 1'b0;
			trig_r   <= 1'b0;
			pulse_r  <= 1'b0;
			tog_r    <= 1'b0;
			src_d_r  <= 1'b0;
			gate_d_r <= 1'b0;
		end else begin
			src_d_r  <= src_lvl;
			gate_d_r <= gate_lvl;
			pulse_r  <= pulse_nxt;
			tog_r    <= tog_nxt;
			if (wr_ctrl) begin
				ctrl_r <= wdata[`EECNT_CTRL_W-1:0];
			end
			if (wr_load) begin
				load_r <= wdata[CW-1:0];
			end
			// Preload takes priority over a coincident edge
			if (cmd_ld) begin
				cnt_r <= load_r;
			end else begin
				cnt_r <= cnt_nxt;
			end
			// Software start arms counting; edge gating modes wait for their gate edge
			if (cmd_st) begin
				run_r  <= 1'b0;
				trig_r <= 1'b0;
			end else if (cmd_go) begin
				run_r  <= 1'b1;
				trig_r <= 1'b0;
			end else if (trig_ev) begin
				trig_r <= 1'b1;
			end
		end
	end

	// Interrupt state and pin outputs, all registered
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_r    <= {`EECNT_EV_W{1'b0}};
			ien_r     <= {`EECNT_EV_W{1'b0}};
			irq_r     <= 1'b0;
			ctr_out_r <= 1'b0;
		end else begin
			stat_r    <= stat_nxt;
			ien_r     <= ien_nxt;
			irq_r     <= |(stat_nxt & ien_nxt);
			ctr_out_r <= out_nxt;
		end
	end

	// Read mux; reading has no side effects on the count or the run state
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		case (addr)
			`EECNT_OFS_CTRL:   rd_mux[`EECNT_CTRL_W-1:0] = ctrl_r;
			`EECNT_OFS_LOAD:   rd_mux[CW-1:0] = load_r;
			`EECNT_OFS_COUNT:  rd_mux[CW-1:0] = cnt_r;
			`EECNT_OFS_STATUS: rd_mux[`EECNT_EV_W-1:0] = stat_r;
			`EECNT_OFS_IRQ_EN: rd_mux[`EECNT_EV_W-1:0] = ien_r;
			`EECNT_OFS_STATE:  rd_mux[3:0] = {ctr_out_r, gate_lvl, trig_r, run_r};
			default:           rd_mux = 32'h00000000; // Unmapped and write-only read as zero
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			rdata <= rd_mux;
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule // eecnt_top

// *** tb/eecnt_sva.sv ***
// Port-level assertions for the edge event counter
`timescale 1ns/1ps
module eecnt_sva (
	input logic        clk,
	input logic        arst_n,
	input logic        src_pin,
	input logic        gate_pin,
	input logic        dir_pin,
	input logic [7:0]  addr,
	input logic [31:0] wdata,
	input logic        wr,
	input logic        rd,
	input logic [31:0] rdata,
	input logic        ctr_out_r,
	input logic        irq_r
);
	logic       src_q_r;
	logic [3:0] quiet_r;
	logic [1:0] om_r;
	logic [1:0] en_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Cycles since the source pin moved, plus shadows of output mode and enables
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_q_r <= 1'b0;
			quiet_r <= 4'h0;
			om_r    <= 2'h0;
			en_r    <= 2'h0;
		end else begin
			src_q_r <= src_pin;
			quiet_r <= (src_pin != src_q_r) ? 4'h0 : (quiet_r == 4'hF ? quiet_r : quiet_r + 4'h1);
			if (wr && addr == 8'h00)
				om_r <= wdata[4:3];
			if (wr && addr == 8'h14)
				en_r <= wdata[1:0];
		end
	end
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	a_dead_reads: assert property (rd && (addr == 8'h0C || addr == 8'h18 || addr >= 8'h20) |=> rdata == 32'h0)
		else $error("write-only or unmapped read not zero");
	a_load_back: assert property (wr && addr == 8'h04 ##2 rd && addr == 8'h04 |=> rdata == $past(wdata, 3))
		else $error("preload value not read back");
	// Without source activity two count reads must agree
	a_count_steady: assert property (quiet_r >= 4'h7 && rd && addr == 8'h08 ##2 rd && addr == 8'h08
		|=> rdata == $past(rdata, 2))
		else $error("count moved without counted edge");
	a_out_cause: assert property ($changed(ctr_out_r) |-> $past(wr) || $past(wr, 2)
		|| (quiet_r >= 4'h2 && quiet_r <= 4'h6))
		else $error("output moved without counted edge");
	a_pulse_hold: assert property (om_r == 2'h0 && $rose(ctr_out_r) |=> ctr_out_r [*4])
		else $error("pulse shorter than a source period");
	a_irq_masked: assert property (en_r == 2'h0 && $past(en_r) == 2'h0 |-> !irq_r)
		else $error("interrupt high while masked");
	a_clr_drop: assert property (wr && addr == 8'h18 && wdata[0] && en_r == 2'h1 && quiet_r >= 4'h7
		|-> ##2 !irq_r)
		else $error("interrupt not cleared");
endmodule // eecnt_sva

bind eecnt_top eecnt_sva u_sva (.clk(clk), .arst_n(arst_n), .src_pin(src_pin), .gate_pin(gate_pin),
	.dir_pin(dir_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.ctr_out_r(ctr_out_r), .irq_r(irq_r));

// *** tb/eecnt_src_model.sv ***
// Far-side source, gate and direction drivers for the edge event counter
`timescale 1ns/1ps
module eecnt_src_model (
	input  logic clk,
	output logic src_pin,
	output logic gate_pin,
	output logic dir_pin
);
	// Each level held 8 clocks so the pin filter and count latency settle
	task automatic lvl(input logic v);
		src_pin <= v;
		repeat (8) @(posedge clk);
	endtask
	// Whole pulses, a rising then a falling edge each
	task automatic pulses(input int n);
		repeat (n) begin
			lvl(1'b1);
			lvl(1'b0);
		end
	endtask
	// Gate and direction change only between source edges
	task automatic pins(input logic g, input logic d);
		gate_pin <= g;
		dir_pin  <= d;
		repeat (8) @(posedge clk);
	endtask
	initial begin
		src_pin  = 1'b0;
		gate_pin = 1'b0;
		dir_pin  = 1'b0;
	end
endmodule // eecnt_src_model

// *** tb/tb_top.sv ***
// Self-checking bench for the edge event counter
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        arst_n;
	logic        src_pin;
	logic        gate_pin;
	logic        dir_pin;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        ctr_out_r;
	logic        irq_r;
	int          num_errors = 0;
	int          checked = 0;
	int          cyc = 0;
	eecnt_top dut (.clk(clk), .arst_n(arst_n), .src_pin(src_pin), .gate_pin(gate_pin), .dir_pin(dir_pin),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ctr_out_r(ctr_out_r), .irq_r(irq_r));
	eecnt_src_model src (.clk(clk), .src_pin(src_pin), .gate_pin(gate_pin), .dir_pin(dir_pin));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic summarize();
		$display("Checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// A hang costs a mismatch; the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so look just past that edge
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// Configure, preload, then start by software
	task automatic arm(input logic [7:0] c, input logic [31:0] v);
		wr_reg(8'h00, {24'h0, c});
		wr_reg(8'h04, v);
		wr_reg(8'h0C, 32'h1);
		wr_reg(8'h0C, 32'h2);
	endtask
	task automatic t_regs();
		rd_chk(8'h00, 32'h0);
		rd_chk(8'h10, 32'h0);
		wr_reg(8'h04, 32'hA5A5A5A5);
		rd_chk(8'h04, 32'hA5A5A5A5);
		rd_chk(8'h0C, 32'h0);
		rd_chk(8'h20, 32'h0);
	endtask
	task automatic t_up();
		wr_reg(8'h14, 32'h1);
		arm(8'h00, 32'hFFFFFFFC);
		rd_chk(8'h08, 32'hFFFFFFFC);
		src.pulses(2);
		rd_chk(8'h08, 32'hFFFFFFFE);
		rd_chk(8'h08, 32'hFFFFFFFE);
		src.pulses(1);
		chk(32'({ctr_out_r, irq_r}), 32'h3);
		src.pulses(1);
		chk(32'(ctr_out_r), 32'h0);
		rd_chk(8'h08, 32'h0);
		wr_reg(8'h18, 32'h1);
		repeat (2) @(posedge clk);
		chk(32'(irq_r), 32'h0);
	endtask
	task automatic t_down_tog();
		arm(8'h09, 32'h3);
		src.pulses(3);
		chk(32'({ctr_out_r, irq_r}), 32'h3);
		rd_chk(8'h08, 32'h0);
		wr_reg(8'h14, 32'h0);
		src.pulses(1);
		rd_chk(8'h08, 32'hFFFFFFFF);
		chk(32'({ctr_out_r, irq_r}), 32'h2);
		wr_reg(8'h18, 32'h3);
	endtask
	task automatic t_fall_gate();
		arm(8'h04, 32'h0);
		src.lvl(1'b1);
		rd_chk(8'h08, 32'h0);
		src.lvl(1'b0);
		rd_chk(8'h08, 32'h1);
		arm(8'h20, 32'h0);
		src.pulses(1);
		rd_chk(8'h08, 32'h0);
		src.pins(1'b1, 1'b0);
		src.pulses(1);
		rd_chk(8'h08, 32'h1);
	endtask
	task automatic t_dir_stop();
		arm(8'h02, 32'h5);
		src.pins(1'b1, 1'b1);
		src.pulses(1);
		rd_chk(8'h08, 32'h4);
		src.pins(1'b1, 1'b0);
		src.pulses(1);
		rd_chk(8'h08, 32'h5);
		wr_reg(8'h0C, 32'h4);
		src.pulses(1);
		rd_chk(8'h08, 32'h5);
	endtask
	// Start on gate rise, then low-level gating with the gate held high
	task automatic t_trig_low();
		arm(8'h60, 32'h0);
		src.pulses(1);
		rd_chk(8'h08, 32'h0);
		src.pins(1'b0, 1'b0);
		src.pins(1'b1, 1'b0);
		src.pulses(1);
		rd_chk(8'h08, 32'h1);
		rd_chk(8'h10, 32'h2);
		rd_chk(8'h1C, 32'h7);
		arm(8'h40, 32'h0);
		src.pulses(1);
		rd_chk(8'h08, 32'h0);
	endtask
	initial begin
		arst_n = 1'b0;
		wr     = 1'b0;
		rd     = 1'b0;
		addr   = 8'h00;
		wdata  = 32'h0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_up();
		t_down_tog();
		t_fall_gate();
		t_dir_stop();
		t_trig_low();
		summarize();
	end
endmodule // tb_top
